//--- src/sbt_arbiter.sv
// serial bit timer and bus arbiter with an axi4-lite register slave
`timescale 1ns/1ps
module sbt_arbiter
    import sbt_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [SBT_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [SBT_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rx_in,
    input wire logic internal_transmit_out,
    input wire logic prescaler_tick_bus,
    input wire logic prescaler_tick_osc,
    output logic tx_pin
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // read view of the control/status register
    function automatic logic [7:0] sbt_ctrl_view(input sbt_state_type s);
        logic [7:0] v;
        v = 8'h00;
        v[SBT_BIT_MODE_HI] = s.mode[1];
        v[SBT_BIT_MODE_LO] = s.mode[0];
        v[SBT_BIT_LOST] = s.lost;
        v[SBT_BIT_CLKSEL] = s.clk_sel;
        v[SBT_BIT_DONE] = s.done;
        v[SBT_BIT_RUN] = (s.phase == SBT_COUNT);
        v[SBT_BIT_OVF] = s.ovf;
        v[SBT_BIT_TOP] = s.count[SBT_CNT_W-1];
        return v;
    endfunction

    // true when an address hits one of the three mapped words
    function automatic logic sbt_mapped(input logic [SBT_ADDR_W-1:0] a);
        return (a == SBT_OFF_CTRL) || (a == SBT_OFF_COUNT) || (a == SBT_OFF_CONFIG);
    endfunction

    sbt_state_type st_reg;
    sbt_state_type st_next;

    // decoded strobes, also watched by the checks below
    logic tick;
    logic presc_tick;
    logic rx_fall;
    logic rx_rise;
    logic tx_rise;
    logic tx_fall;
    logic ctrl_wr;
    logic done_set;
    logic ovf_set;
    logic lost_set;
    logic lost_clr;

    // ------------------------------------------------------------
    // counter clock enable
    // ------------------------------------------------------------
    // the prescaler itself lives outside; only its tick is chosen here
    assign presc_tick = st_reg.src_sel ? prescaler_tick_osc : prescaler_tick_bus;
    assign tick = st_reg.clk_sel ? (presc_tick & st_reg.half_tgl)
                                 : (st_reg.div4 == SBT_DIV4_LAST);

    // receive edges seen only on synchronised samples, never the first stage; transmit edges come from the raw input
    assign rx_fall = st_reg.rx_prev & ~st_reg.rx_sync;
    assign rx_rise = ~st_reg.rx_prev & st_reg.rx_sync;
    assign tx_rise = ~st_reg.tx_prev & internal_transmit_out;
    assign tx_fall = st_reg.tx_prev & ~internal_transmit_out;

    assign ctrl_wr = st_reg.aw_full && st_reg.w_full && !st_reg.bvalid
                     && st_reg.w_strb0 && (st_reg.aw_addr == SBT_OFF_CTRL);
    assign lost_clr = ctrl_wr && !st_reg.w_data[SBT_BIT_MODE_HI];

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        done_set = 1'b0;
        ovf_set = 1'b0;
        lost_set = 1'b0;

        // two-stage receive synchroniser plus an edge history stage
        st_next.rx_meta = rx_in;
        st_next.rx_sync = st_reg.rx_meta;
        st_next.rx_prev = st_reg.rx_sync;
        st_next.tx_prev = internal_transmit_out;

        // free-running quarter divider and prescaler halving toggle
        st_next.div4 = st_reg.div4 + SBT_DIV4_STEP;
        if (presc_tick) begin
            st_next.half_tgl = ~st_reg.half_tgl;
        end

        // counting with wrap detection
        if (st_reg.phase == SBT_COUNT && tick) begin
            st_next.count = st_reg.count + SBT_CNT_ONE;
            if (st_reg.count == SBT_CNT_MAX) begin
                ovf_set = 1'b1;
            end
        end

        // mode engine
        unique case (st_reg.mode)
            SBT_MODE_MEASURE: begin
                unique case (st_reg.phase)
                    SBT_IDLE: begin
                        st_next.phase = SBT_WAIT;
                    end
                    SBT_WAIT: begin
                        if (!st_reg.clk_sel && rx_fall) begin
                            st_next.phase = SBT_COUNT;
                            st_next.count = '0;
                        end else if (st_reg.clk_sel && !st_reg.rx_sync) begin
                            st_next.phase = SBT_COUNT;
                            st_next.count = '0;
                        end
                    end
                    SBT_COUNT: begin
                        if (!st_reg.clk_sel && rx_fall) begin
                            st_next.phase = SBT_STOP;
                            st_next.count = st_reg.count;
                            done_set = 1'b1;
                        end else if (st_reg.clk_sel && rx_rise) begin
                            st_next.phase = SBT_STOP;
                            st_next.count = st_reg.count;
                            done_set = 1'b1;
                        end
                    end
                    SBT_STOP: begin
                        st_next.phase = SBT_STOP;
                    end
                    default: begin
                        st_next.phase = SBT_IDLE;
                    end
                endcase
            end
            SBT_MODE_ARBITRATE: begin
                if (st_reg.phase == SBT_IDLE) begin
                    st_next.phase = SBT_WAIT;
                end
                if (tx_rise) begin
                    st_next.phase = SBT_COUNT;
                    st_next.count = '0;
                    st_next.sampled = 1'b0;
                end else if (st_reg.phase == SBT_COUNT) begin
                    // one static sample per transmitted bit
                    if (!st_reg.sampled && st_reg.count ==
                        (st_reg.clk_sel ? SBT_SAMPLE_PRESC : SBT_SAMPLE_BUS)) begin
                        st_next.sampled = 1'b1;
                        lost_set = !st_reg.rx_sync;
                    end
                    // own dominant bit with no conflict seen: re-arm quietly
                    if (tx_fall && !st_reg.lost) begin
                        st_next.phase = SBT_WAIT;
                        st_next.count = '0;
                    end
                end
            end
            default: begin
                // idle and the unused code both hold the counter cleared
                st_next.phase = SBT_IDLE;
                st_next.count = '0;
                st_next.sampled = 1'b0;
            end
        endcase

        // ------------------------------------------------------------
        // axi4-lite write channel
        // ------------------------------------------------------------
        if (s_axi_awvalid && st_reg.awready) begin
            st_next.aw_full = 1'b1;
            st_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_reg.wready) begin
            st_next.w_full = 1'b1;
            st_next.w_data = s_axi_wdata;
            st_next.w_strb0 = s_axi_wstrb[0];
        end
        if (st_reg.aw_full && st_reg.w_full && !st_reg.bvalid) begin
            st_next.aw_full = 1'b0;
            st_next.w_full = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = sbt_mapped(st_reg.aw_addr) ? SBT_RESP_OKAY : SBT_RESP_SLVERR;
            if (ctrl_wr) begin
                // a control write with byte 0 strobed restarts the chosen mode; only a write with mode bit 7 low also clears lost
                st_next.mode = {st_reg.w_data[SBT_BIT_MODE_HI], st_reg.w_data[SBT_BIT_MODE_LO]};
                st_next.clk_sel = st_reg.w_data[SBT_BIT_CLKSEL];
                st_next.count = '0;
                st_next.phase = SBT_IDLE;
                st_next.sampled = 1'b0;
            end
            if (st_reg.w_strb0 && st_reg.aw_addr == SBT_OFF_CONFIG) begin
                st_next.src_sel = st_reg.w_data[SBT_BIT_SRCSEL];
            end
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        st_next.awready = !st_next.aw_full && !st_next.bvalid;
        st_next.wready = !st_next.w_full && !st_next.bvalid;

        // flags: a hardware set in the same cycle beats the software clear
        st_next.done = (st_reg.done & ~ctrl_wr) | done_set;
        st_next.ovf = (st_reg.ovf & ~ctrl_wr) | ovf_set;
        st_next.lost = (st_reg.lost & ~lost_clr) | lost_set;

        // transmit pin follows the next flag so it seizes in the same cycle
        st_next.tx_pin = st_next.lost ? 1'b1 : internal_transmit_out;

        // ------------------------------------------------------------
        // axi4-lite read channel
        // ------------------------------------------------------------
        if (s_axi_arvalid && st_reg.arready) begin
            st_next.rvalid = 1'b1;
            st_next.rresp = sbt_mapped(s_axi_araddr) ? SBT_RESP_OKAY : SBT_RESP_SLVERR;
            st_next.rdata = 32'h0000_0000;
            if (s_axi_araddr == SBT_OFF_CTRL) begin
                st_next.rdata[7:0] = sbt_ctrl_view(st_reg);
            end else if (s_axi_araddr == SBT_OFF_COUNT) begin
                st_next.rdata[7:0] = st_reg.count[7:0];
            end else if (s_axi_araddr == SBT_OFF_CONFIG) begin
                st_next.rdata[SBT_BIT_SRCSEL] = st_reg.src_sel;
            end
        end else if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        st_next.arready = !st_next.rvalid;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // receive history resets high, matching an idle serial line
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
            st_reg.phase <= SBT_IDLE;
            st_reg.rx_meta <= 1'b1;
            st_reg.rx_sync <= 1'b1;
            st_reg.rx_prev <= 1'b1;
            st_reg.tx_prev <= 1'b1;
            st_reg.tx_pin <= 1'b1;
            st_reg.bresp <= SBT_RESP_OKAY;
            st_reg.rresp <= SBT_RESP_OKAY;
        end else begin
            st_reg <= st_next;
        end
    end

    assign s_axi_awready = st_reg.awready;
    assign s_axi_wready = st_reg.wready;
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_arready = st_reg.arready;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rdata = st_reg.rdata;
    assign s_axi_rresp = st_reg.rresp;
    assign tx_pin = st_reg.tx_pin;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_idle_hold;
        @(posedge aclk) disable iff (!aresetn)
        (st_reg.mode == SBT_MODE_IDLE) |-> (st_reg.count == '0 && st_reg.phase == SBT_IDLE);
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("counter not held in idle");

    property p_fall_start;
        @(posedge aclk) disable iff (!aresetn)
        (st_reg.mode == SBT_MODE_MEASURE && !st_reg.clk_sel && st_reg.phase == SBT_WAIT
         && rx_fall && !ctrl_wr) |=> (st_reg.phase == SBT_COUNT && st_reg.count == '0);
    endproperty
    a_fall_start: assert property (p_fall_start) else $error("falling edge did not start");

    property p_fall_stop;
        @(posedge aclk) disable iff (!aresetn)
        (st_reg.mode == SBT_MODE_MEASURE && !st_reg.clk_sel && st_reg.phase == SBT_COUNT
         && rx_fall && !ctrl_wr) |=> (st_reg.done && st_reg.count == $past(st_reg.count));
    endproperty
    a_fall_stop: assert property (p_fall_stop) else $error("second falling edge did not stop");

    property p_low_start;
        @(posedge aclk) disable iff (!aresetn)
        (st_reg.mode == SBT_MODE_MEASURE && st_reg.clk_sel && st_reg.phase == SBT_WAIT
         && !st_reg.rx_sync && !ctrl_wr) |=> (st_reg.phase == SBT_COUNT);
    endproperty
    a_low_start: assert property (p_low_start) else $error("low receive did not start");

    property p_wrap;
        @(posedge aclk) disable iff (!aresetn)
        (st_reg.phase == SBT_COUNT && tick && st_reg.count == SBT_CNT_MAX && !ctrl_wr)
        |=> (st_reg.ovf && st_reg.count == '0);
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap did not flag overflow");

    property p_ctrl_clear;
        @(posedge aclk) disable iff (!aresetn)
        (ctrl_wr && !done_set && !ovf_set) |=> (!st_reg.done && !st_reg.ovf && st_reg.count == '0);
    endproperty
    a_ctrl_clear: assert property (p_ctrl_clear) else $error("control write did not clear");

    property p_lost_keep;
        @(posedge aclk) disable iff (!aresetn)
        (st_reg.lost && !lost_clr) |=> st_reg.lost;
    endproperty
    a_lost_keep: assert property (p_lost_keep) else $error("lost flag cleared without write");

    property p_sample;
        @(posedge aclk) disable iff (!aresetn)
        (st_reg.mode == SBT_MODE_ARBITRATE && st_reg.phase == SBT_COUNT && !tx_rise
         && !st_reg.sampled && !st_reg.rx_sync && !ctrl_wr
         && st_reg.count == (st_reg.clk_sel ? SBT_SAMPLE_PRESC : SBT_SAMPLE_BUS))
        |=> st_reg.lost;
    endproperty
    a_sample: assert property (p_sample) else $error("low sample did not set lost");

    property p_seize;
        @(posedge aclk) disable iff (!aresetn)
        st_reg.lost |-> tx_pin;
    endproperty
    a_seize: assert property (p_seize) else $error("transmit pin not forced high");

    property p_restart;
        @(posedge aclk) disable iff (!aresetn)
        (st_reg.mode == SBT_MODE_ARBITRATE && tx_rise && !ctrl_wr)
        |=> (st_reg.phase == SBT_COUNT && st_reg.count == '0 && !st_reg.sampled);
    endproperty
    a_restart: assert property (p_restart) else $error("transmit edge did not restart");

    // a later control write may switch to prescaler ticks, which then keep their own spacing
    property p_quarter;
        @(posedge aclk) disable iff (!aresetn)
        (!st_reg.clk_sel && tick && !ctrl_wr)
        |=> (!tick || st_reg.clk_sel) [*3] ##1 (tick || st_reg.clk_sel);
    endproperty
    a_quarter: assert property (p_quarter) else $error("quarter clock spacing wrong");

endmodule

//--- src/sbt_pkg.sv
// constants, register map and state types for the serial bit timer and arbiter
package sbt_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses of aligned 32-bit words)
    // ------------------------------------------------------------
    localparam int SBT_ADDR_W = 8;
    localparam logic [SBT_ADDR_W-1:0] SBT_OFF_CTRL = 8'h00;
    localparam logic [SBT_ADDR_W-1:0] SBT_OFF_COUNT = 8'h04;
    localparam logic [SBT_ADDR_W-1:0] SBT_OFF_CONFIG = 8'h08;

    // control/status bit positions, then the source select bit of the config word
    localparam int SBT_BIT_MODE_HI = 7;
    localparam int SBT_BIT_MODE_LO = 6;
    localparam int SBT_BIT_LOST = 5;
    localparam int SBT_BIT_CLKSEL = 4;
    localparam int SBT_BIT_DONE = 3;
    localparam int SBT_BIT_RUN = 2;
    localparam int SBT_BIT_OVF = 1;
    localparam int SBT_BIT_TOP = 0;
    localparam int SBT_BIT_SRCSEL = 0;

    // ------------------------------------------------------------
    // modes, counter and timing
    // ------------------------------------------------------------
    localparam logic [1:0] SBT_MODE_IDLE = 2'h0;
    localparam logic [1:0] SBT_MODE_MEASURE = 2'h1;
    localparam logic [1:0] SBT_MODE_ARBITRATE = 2'h2;
    localparam logic [1:0] SBT_MODE_RESERVED = 2'h3;
    localparam int SBT_CNT_W = 9;
    localparam logic [SBT_CNT_W-1:0] SBT_CNT_MAX = 9'h1ff;
    localparam logic [SBT_CNT_W-1:0] SBT_CNT_ONE = 9'h001;
    localparam logic [SBT_CNT_W-1:0] SBT_SAMPLE_BUS = 9'h038;
    localparam logic [SBT_CNT_W-1:0] SBT_SAMPLE_PRESC = 9'h008;
    localparam logic [1:0] SBT_DIV4_LAST = 2'h3;
    localparam logic [1:0] SBT_DIV4_STEP = 2'h1;
    localparam logic [1:0] SBT_RESP_OKAY = 2'h0;
    localparam logic [1:0] SBT_RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        SBT_IDLE = 4'b0001,
        SBT_WAIT = 4'b0010,
        SBT_COUNT = 4'b0100,
        SBT_STOP = 4'b1000
    } sbt_phase_type;

    // ------------------------------------------------------------
    // whole module state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] mode;
        logic clk_sel;
        logic lost;
        logic done;
        logic ovf;
        logic [SBT_CNT_W-1:0] count;
        logic src_sel;
        sbt_phase_type phase;
        logic sampled;
        logic rx_meta;
        logic rx_sync;
        logic rx_prev;
        logic tx_prev;
        logic [1:0] div4;
        logic half_tgl;
        logic tx_pin;
        logic awready;
        logic aw_full;
        logic [SBT_ADDR_W-1:0] aw_addr;
        logic wready;
        logic w_full;
        logic [31:0] w_data;
        logic w_strb0;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } sbt_state_type;

endpackage

//--- verif/sbt_bus_node.sv
// model of the other nodes sharing the serial bus
`timescale 1ns/1ps
module sbt_bus_node (
    input wire logic tx_pin,
    input wire logic dominant,
    output logic bus_line
);
    // wired-and bus with a pull-up: any dominant node pulls it low, idle is high
    assign bus_line = tx_pin & ~dominant;
endmodule

//--- verif/serial_bit_timer_arbiter_tb.sv
// self-checking bench for the serial bit timer and arbiter
`timescale 1ns/1ps
module serial_bit_timer_arbiter_tb
    import sbt_pkg::*;
;
    // ----------------------------------------
    // signals, clocks and instances
    // ----------------------------------------
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, dominant = 1'b0;
    logic internal_transmit_out = 1'b1, prescaler_tick_bus = 1'b0, prescaler_tick_osc = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rx_in, tx_pin;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata, rd;
    int failures = 0, samples_checked = 0, seed = 32'h163d19f1, cyc = 0, t0, n, cnt;
    always #5 aclk = ~aclk;
    // prescaler ticks: bus source every 2nd cycle, oscillator every 3rd
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        prescaler_tick_bus <= (cyc % 2 == 0);
        prescaler_tick_osc <= (cyc % 3 == 0);
    end
    sbt_arbiter sbt_arbiter_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_in, .internal_transmit_out,
        .prescaler_tick_bus, .prescaler_tick_osc, .tx_pin);
    sbt_bus_node sbt_bus_node_i (.tx_pin(tx_pin), .dominant(dominant), .bus_line(rx_in));
    // ----------------------------------------
    // checking and bus tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    task automatic complete_run();
        $display("checked %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic wt(input int k);
        repeat (k) @(posedge aclk);
    endtask
    // a handshake that never comes counts as a mismatch and closes the run
    task automatic give_up(input int k);
        if (k >= 50) begin
            failures++;
            $display("mismatch at %0t: no handshake", $time);
            complete_run();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int k = 0;
        bit ad = 0;
        bit wd = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(ad && wd) && k < 50) begin
            @(posedge aclk);
            k++;
            if (s_axi_awvalid && s_axi_awready === 1'b1) begin
                ad = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready === 1'b1) begin
                wd = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        give_up(k);
        s_axi_bready <= 1'b1;
        k = 0;
        do begin
            @(posedge aclk);
            k++;
        end while (s_axi_bvalid !== 1'b1 && k < 50);
        give_up(k);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a);
        int k = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            k++;
        end while (s_axi_arready !== 1'b1 && k < 50);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            k++;
        end while (s_axi_rvalid !== 1'b1 && k < 50);
        give_up(k);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // ----------------------------------------
    // main sequence against the integer model
    // ----------------------------------------
    initial begin
        wt(6);
        aresetn <= 1'b1;
        rdr(SBT_OFF_CTRL);
        chk(rd, 32'h0);
        chk(tx_pin, 1'b1);
        wr(SBT_OFF_COUNT, 32'hff, 4'h1);
        chk(rsp, SBT_RESP_OKAY);
        rdr(SBT_OFF_COUNT);
        chk(rd, 32'h0);
        wr(8'h0c, 32'h1, 4'h1);
        chk(rsp, SBT_RESP_SLVERR);
        rdr(8'h0c);
        chk(rsp, SBT_RESP_SLVERR);
        $display("test registers done");
        // idle and reserved modes hold the counter at zero whatever the line does
        for (int m = 0; m < 4; m += 3) begin
            wr(SBT_OFF_CTRL, m << 6, 4'h1);
            dominant <= 1'b1;
            wt(20);
            dominant <= 1'b0;
            wt(20);
            rdr(SBT_OFF_COUNT);
            chk(rd, 32'h0);
        end
        $display("test idle modes done");
        // edge to edge measurement, the last one long enough to wrap the counter
        for (int i = 0; i < 3; i++) begin
            n = (i == 2) ? 2100 : 40 + ($random(seed) & 255);
            wr(SBT_OFF_CTRL, 32'h40, 4'h1);
            wt(4);
            dominant <= 1'b1;
            t0 = cyc;
            wt(6);
            rdr(SBT_OFF_CTRL);
            chk(rd[3:2], 2'b01);
            dominant <= 1'b0;
            wt(n);
            dominant <= 1'b1;
            n = (cyc - t0) / 4;
            wt(8);
            dominant <= 1'b0;
            rdr(SBT_OFF_COUNT);
            cnt = rd;
            rdr(SBT_OFF_CTRL);
            chk(rd, n > 511 ? 32'h4a : 32'h48);
            cnt = cnt + 256 * rd[0];
            chk(cnt + 1 >= n % 512 && cnt <= n % 512 + 1, 1'b1);
        end
        $display("test edge measurement done");
        // low pulse with oscillator ticks, line already low when enabled
        wr(SBT_OFF_CONFIG, 32'h1, 4'h1);
        dominant <= 1'b1;
        wr(SBT_OFF_CTRL, 32'h50, 4'h1);
        t0 = cyc;
        wt(60 + ($random(seed) & 127));
        rdr(SBT_OFF_CTRL);
        chk(rd[2], 1'b1);
        dominant <= 1'b0;
        n = (cyc - t0) / 6;
        wt(8);
        rdr(SBT_OFF_COUNT);
        chk(rd + 1 >= n && rd <= n + 1, 1'b1);
        rdr(SBT_OFF_CTRL);
        chk(rd, 32'h58);
        $display("test low pulse done");
        // arbitration lost: another node is dominant at the sample point
        wr(SBT_OFF_CONFIG, 32'h0, 4'h1);
        internal_transmit_out <= 1'b0;
        wr(SBT_OFF_CTRL, 32'h90, 4'h1);
        internal_transmit_out <= 1'b1;
        wt(12);
        dominant <= 1'b1;
        wt(40);
        dominant <= 1'b0;
        internal_transmit_out <= 1'b0;
        wt(4);
        chk(tx_pin, 1'b1);
        rdr(SBT_OFF_CTRL);
        chk(rd & 32'hf8, 32'hb0);
        wr(SBT_OFF_CTRL, 32'h90, 4'h1);
        wr(SBT_OFF_CTRL, 32'h00, 4'h0);
        rdr(SBT_OFF_CTRL);
        chk(rd & 32'hf8, 32'hb0);
        wr(SBT_OFF_CTRL, 32'h00, 4'h1);
        rdr(SBT_OFF_CTRL);
        chk(rd, 32'h0);
        chk(tx_pin, 1'b0);
        // arbitration kept, then transmit falls and later restarts the count
        wr(SBT_OFF_CTRL, 32'h80, 4'h1);
        internal_transmit_out <= 1'b1;
        wt(300);
        chk(tx_pin, 1'b1);
        rdr(SBT_OFF_CTRL);
        chk(rd, 32'h84);
        internal_transmit_out <= 1'b0;
        wt(6);
        rdr(SBT_OFF_COUNT);
        chk(rd, 32'h0);
        rdr(SBT_OFF_CTRL);
        chk(rd, 32'h80);
        internal_transmit_out <= 1'b1;
        wt(40);
        rdr(SBT_OFF_COUNT);
        chk(rd > 6 && rd < 16, 1'b1);
        aresetn <= 1'b0;
        wt(2);
        aresetn <= 1'b1;
        rdr(SBT_OFF_CTRL);
        chk(rd, 32'h0);
        rdr(SBT_OFF_COUNT);
        chk(rd, 32'h0);
        $display("test arbitration done");
        complete_run();
    end
endmodule
